// ### core/adc_port_pkg.sv
// Shared constants, types and carriers of the serial converter port
// Notes on behaviour
// - Select falling edge holds sample, starts conversion
// - Output leaves high impedance, drives low converting
// - Output high impedance while select is high
// - Output driven high marks end of conversion
// - Conversion needs no serial clock; result kept
// - Result shifts out only on serial clock edges
// - Output changes on falling edges, MSB first
// - Extra clocks shift zeros, converter undisturbed
// - Byte reads: marker plus seven, five plus zeros
// - Result is straight unipolar binary code
// - Floating shutdown pin disables internal reference
// - Shutdown low powers down; high or floating runs
package adc_port_pkg;

  // ==========================================================
  // Sizes and timing
  localparam int RES_BITS = 12;
  localparam int FRAME_BITS = RES_BITS + 1;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_MAX_NS = 7500;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int STEP_CYC = CONV_MAX_CYC / (RES_BITS + 1);
  localparam int STEP_W = 5;
  localparam int FIFO_DEPTH = 16;
  localparam logic LEAD_BIT = 1'b1;
  localparam logic [RES_BITS-1:0] MSB_TRIAL = 12'h800;
  localparam logic [3:0] TOP_BIT_IDX = 4'hb;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_READ = 2'b10
  } port_state_t;

  typedef struct packed {
    logic [RES_BITS-1:0] code;
  } conv_word_t;

  typedef struct packed {
    logic powerDownNFloat;
    logic powerDownNIsLow;
    logic cmpHigh;
    logic sclk;
    logic selectN;
  } pin_in_t;

  // Idle pin levels, so no false select edge follows reset
  localparam pin_in_t PINS_IDLE = '{
    powerDownNFloat: 1'b0,
    powerDownNIsLow: 1'b0,
    cmpHigh: 1'b0,
    sclk: 1'b0,
    selectN: 1'b1
  };

endpackage

// ### core/sample_fifo.sv
// Parameterised result FIFO with valid and ready on both sides
`timescale 1ns/1ns
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic flush,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_r;
  logic [AW:0] wrPtr_nxt;
  logic [AW:0] rdPtr_r;
  logic [AW:0] rdPtr_nxt;
  logic doPush;
  logic doPop;
  logic full;
  logic empty;

  // ==========================================================
  // Status and handshakes
  assign empty = (wrPtr_r == rdPtr_r);
  assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_r[AW-1:0]];
  assign doPush = inValid && !full && !flush;
  assign doPop = outReady && !empty;

  always_comb
  begin
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    if (flush)
    begin
      rdPtr_nxt = wrPtr_r;
    end
    else
    begin
      if (doPush)
      begin
        wrPtr_nxt = wrPtr_r + {{AW{1'b0}}, 1'b1};
      end
      if (doPop)
      begin
        rdPtr_nxt = rdPtr_r + {{AW{1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (doPush)
    begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end

endmodule // sample_fifo

// ### core/serial_adc_port.sv
// Conversion control and serial readout of the twelve-bit converter
`timescale 1ns/1ns
module serial_adc_port #(
  parameter int FIFO_DEPTH = adc_port_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins and comparator
  input wire adc_port_pkg::pin_in_t pinsIn,
  // Serial output pin
  output logic dout,
  output logic doutOe,
  // Analog control
  output logic holdSample,
  output logic [adc_port_pkg::RES_BITS-1:0] dacCode,
  output logic refEnable,
  output logic powerUp
);

  import adc_port_pkg::*;

  // ==========================================================
  // Pin synchronisers
  pin_in_t sync1_r;
  pin_in_t sync2_r;
  logic selPrev_r;
  logic sclkPrev_r;
  logic selFall;
  logic selRise;
  logic sclkFall;
  logic pdLow;
  logic pdFloat;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sync1_r <= PINS_IDLE;
      sync2_r <= PINS_IDLE;
      selPrev_r <= 1'b1;
      sclkPrev_r <= 1'b0;
    end
    else
    begin
      sync1_r <= pinsIn;
      sync2_r <= sync1_r;
      selPrev_r <= sync2_r.selectN;
      sclkPrev_r <= sync2_r.sclk;
    end
  end

  assign selFall = selPrev_r && !sync2_r.selectN;
  assign selRise = !selPrev_r && sync2_r.selectN;
  assign sclkFall = sclkPrev_r && !sync2_r.sclk;
  assign pdLow = sync2_r.powerDownNIsLow;
  assign pdFloat = sync2_r.powerDownNFloat;

  // ==========================================================
  // Shared control terms
  port_state_t state_r;
  port_state_t state_nxt;
  logic startReq;
  logic abortConv;
  logic readAbort;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  conv_word_t fifoOut;
  conv_word_t pushWord;

  assign startReq = selFall && (state_r == ST_IDLE) && !pdLow;
  assign abortConv = (state_r == ST_CONV) && (selRise || pdLow);
  assign readAbort = (state_r == ST_READ) && (selRise || pdLow);
  assign fifoOutReady = (state_r == ST_CONV);

  // ==========================================================
  // Successive approximation engine
  logic sarBusy_r;
  logic sarBusy_nxt;
  logic [3:0] bitIdx_r;
  logic [3:0] bitIdx_nxt;
  logic [STEP_W-1:0] stepCnt_r;
  logic [STEP_W-1:0] stepCnt_nxt;
  logic [RES_BITS-1:0] trial_r;
  logic [RES_BITS-1:0] trial_nxt;
  logic pushValid_r;
  logic pushValid_nxt;

  always_comb
  begin
    sarBusy_nxt = sarBusy_r;
    bitIdx_nxt = bitIdx_r;
    stepCnt_nxt = stepCnt_r;
    trial_nxt = trial_r;
    pushValid_nxt = pushValid_r;
    if (abortConv)
    begin
      sarBusy_nxt = 1'b0;
      pushValid_nxt = 1'b0;
    end
    else if (startReq)
    begin
      // Internal timing only, no serial clock needed
      sarBusy_nxt = 1'b1;
      trial_nxt = MSB_TRIAL;
      bitIdx_nxt = TOP_BIT_IDX;
      stepCnt_nxt = '0;
    end
    else if (pushValid_r)
    begin
      // Stalls here while the FIFO is full
      if (fifoInReady)
      begin
        pushValid_nxt = 1'b0;
      end
    end
    else if (sarBusy_r)
    begin
      if (stepCnt_r == STEP_W'(STEP_CYC - 1))
      begin
        stepCnt_nxt = '0;
        // Keep trial bit when input is above the DAC level
        trial_nxt[bitIdx_r] = sync2_r.cmpHigh;
        if (bitIdx_r == 4'h0)
        begin
          sarBusy_nxt = 1'b0;
          pushValid_nxt = 1'b1;
        end
        else
        begin
          trial_nxt[bitIdx_r - 4'h1] = 1'b1;
          bitIdx_nxt = bitIdx_r - 4'h1;
        end
      end
      else
      begin
        stepCnt_nxt = stepCnt_r + STEP_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sarBusy_r <= 1'b0;
      bitIdx_r <= '0;
      stepCnt_r <= '0;
      trial_r <= '0;
      pushValid_r <= 1'b0;
    end
    else
    begin
      sarBusy_r <= sarBusy_nxt;
      bitIdx_r <= bitIdx_nxt;
      stepCnt_r <= stepCnt_nxt;
      trial_r <= trial_nxt;
      pushValid_r <= pushValid_nxt;
    end
  end

  assign holdSample = sarBusy_r;
  assign dacCode = trial_r;
  assign pushWord.code = trial_r;

  // ==========================================================
  // Result buffer
  sample_fifo #(
    .WIDTH($bits(conv_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .flush(abortConv),
    .inValid(pushValid_r),
    .inReady(fifoInReady),
    .inData(pushWord),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOut)
  );

  // ==========================================================
  // Port state and readout shifter
  logic [FRAME_BITS-1:0] shiftReg_r;
  logic [FRAME_BITS-1:0] shiftReg_nxt;
  logic dout_r;
  logic dout_nxt;
  logic doutOe_r;
  logic doutOe_nxt;

  always_comb
  begin
    state_nxt = state_r;
    shiftReg_nxt = shiftReg_r;
    case (state_r)
      ST_IDLE:
      begin
        if (startReq)
        begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (abortConv)
        begin
          state_nxt = ST_IDLE;
        end
        else if (fifoOutValid)
        begin
          state_nxt = ST_READ;
          shiftReg_nxt = {LEAD_BIT, fifoOut.code};
        end
      end
      ST_READ:
      begin
        if (readAbort)
        begin
          state_nxt = ST_IDLE;
        end
        else if (sclkFall)
        begin
          shiftReg_nxt = {shiftReg_r[FRAME_BITS-2:0], 1'b0};
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    doutOe_nxt = (state_nxt != ST_IDLE);
    dout_nxt = (state_nxt == ST_READ) ? shiftReg_nxt[FRAME_BITS-1] : 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      shiftReg_r <= '0;
      dout_r <= 1'b0;
      doutOe_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      shiftReg_r <= shiftReg_nxt;
      dout_r <= dout_nxt;
      doutOe_r <= doutOe_nxt;
    end
  end

  assign dout = dout_r;
  assign doutOe = doutOe_r;

  // ==========================================================
  // Power and reference control
  logic refEnable_r;
  logic refEnable_nxt;
  logic powerUp_r;
  logic powerUp_nxt;

  always_comb
  begin
    powerUp_nxt = !pdLow;
    refEnable_nxt = !pdLow && !pdFloat;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      refEnable_r <= 1'b0;
      powerUp_r <= 1'b0;
    end
    else
    begin
      refEnable_r <= refEnable_nxt;
      powerUp_r <= powerUp_nxt;
    end
  end

  assign refEnable = refEnable_r;
  assign powerUp = powerUp_r;

  // ==========================================================
  // Checks
  localparam int CONV_BOUND = 200;
  logic fifoTake;
  logic [3:0] shiftCnt_r;

  assign fifoTake = (state_r == ST_CONV) && !abortConv && fifoOutValid;

  always_ff @(posedge sys_clk)
  begin
    if (rst || fifoTake)
    begin
      shiftCnt_r <= '0;
    end
    else if (state_r == ST_READ && sclkFall && shiftCnt_r != 4'hf)
    begin
      shiftCnt_r <= shiftCnt_r + 4'h1;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_start_hold;
    startReq |=> holdSample && doutOe && !dout;
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("conversion start did not hold sample and drive low");

  property p_busy_low;
    (state_r == ST_CONV) ##1 (state_r == ST_CONV) |-> doutOe && !dout;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("output not driven low while converting");

  property p_hiz;
    sync2_r.selectN |=> !doutOe;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("output driven while select high");

  property p_eoc_high;
    fifoTake |=> dout && doutOe && (state_r == ST_READ);
  endproperty
  a_eoc_high: assert property (p_eoc_high)
    else $error("end of conversion not shown as high output");

  property p_conv_bounded;
    startReq |-> ##[1:CONV_BOUND] (state_r != ST_CONV);
  endproperty
  a_conv_bounded: assert property (p_conv_bounded)
    else $error("conversion did not finish in time");

  property p_shift_on_clock;
    (state_r == ST_READ) && !sclkFall |=> $stable(shiftReg_r);
  endproperty
  a_shift_on_clock: assert property (p_shift_on_clock)
    else $error("readout shifted without serial clock edge");

  property p_change_on_fall;
    (state_r == ST_READ) ##1 ((state_r == ST_READ) && $changed(dout)) |-> $past(sclkFall);
  endproperty
  a_change_on_fall: assert property (p_change_on_fall)
    else $error("output changed without serial clock falling edge");

  property p_trailing_zero;
    (state_r == ST_READ) && (shiftCnt_r > 4'hc) |-> !dout;
  endproperty
  a_trailing_zero: assert property (p_trailing_zero)
    else $error("non-zero output after last result bit");

  property p_reload;
    fifoTake |=> shiftReg_r == {LEAD_BIT, $past(fifoOut.code)};
  endproperty
  a_reload: assert property (p_reload)
    else $error("shifter not loaded with marker and result");

  property p_ref_float;
    pdFloat |=> !refEnable;
  endproperty
  a_ref_float: assert property (p_ref_float)
    else $error("reference enabled with floating shutdown pin");

  property p_shutdown;
    pdLow |=> !powerUp && !holdSample;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("device not shut down with pin low");

  c_full_read: cover property ((state_r == ST_READ) && (shiftCnt_r == 4'hd) && selRise);
  c_abort: cover property (abortConv && selRise);
  c_shutdown_abort: cover property (abortConv && pdLow);
  c_trailing: cover property ((state_r == ST_READ) && (shiftCnt_r == 4'hf));

endmodule // serial_adc_port

// ### tb/host_master.sv
// Host serial master model: select line and mode zero serial clock
`timescale 1ns/1ns
module host_master (
  // Clock
  input wire logic sys_clk,
  // Link pins
  input wire logic doutWire,
  output logic selectN,
  output logic sclk
);
  // Six cycles of 40 ns per phase, above the 200 ns minimum
  localparam int HALF_CYC = 6;

  initial
  begin
    selectN = 1'b1;
    sclk = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic start();
    tick(1);
    selectN = 1'b0;
  endtask

  // Raised one cycle after the call, even before the frame is in
  task automatic stop();
    tick(1);
    selectN = 1'b1;
  endtask

  // Clock stays low until the output rises
  task automatic wait_eoc(output int cyc);
    cyc = 0;
    while (doutWire !== 1'b0 && cyc < 50)
    begin
      tick(1);
      cyc++;
    end
    while (doutWire !== 1'b1 && cyc < 250)
    begin
      tick(1);
      cyc++;
    end
  endtask

  // Samples on each rising edge, shifted in first bit highest
  task automatic clock_in(input int n, output logic [15:0] bits);
    bits = 16'h0000;
    for (int i = 0; i < n; i++)
    begin
      tick(HALF_CYC);
      sclk = 1'b1;
      bits = {bits[14:0], doutWire};
      tick(HALF_CYC);
      sclk = 1'b0;
    end
  endtask
endmodule // host_master

// ### tb/test_serial_adc_port.sv
// Self-checking testbench of the serial converter port
`timescale 1ns/1ns
module test_serial_adc_port;
  import adc_port_pkg::*;

  // ==========================================================
  // Signals
  logic sys_clk = 1'b0;
  logic rst;
  logic pdFloat;
  logic pdLow;
  logic [12:0] ain;
  logic cmpHigh;
  logic selectN;
  logic sclk;
  pin_in_t pinsIn;
  logic dout;
  logic doutOe;
  logic holdSample;
  logic [RES_BITS-1:0] dacCode;
  logic refEnable;
  logic powerUp;
  logic lastDout;
  logic doutWire;
  int err_count = 0;
  int checked = 0;

  always #20 sys_clk = ~sys_clk;

  // Comparator in half-LSB units; odd inputs never tie
  assign cmpHigh = (ain > {dacCode, 1'b0});
  assign pinsIn = {pdFloat, pdLow, cmpHigh, sclk, selectN};
  // Released line shows the inverse of the last driven level
  always @(posedge sys_clk)
    if (doutOe === 1'b1)
      lastDout <= dout;
  assign doutWire = (doutOe === 1'b1) ? dout : ~lastDout;

  // ==========================================================
  // Instances
  serial_adc_port #(.FIFO_DEPTH(FIFO_DEPTH)) dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinsIn(pinsIn),
    .dout(dout),
    .doutOe(doutOe),
    .holdSample(holdSample),
    .dacCode(dacCode),
    .refEnable(refEnable),
    .powerUp(powerUp)
  );

  host_master host (
    .sys_clk(sys_clk),
    .doutWire(doutWire),
    .selectN(selectN),
    .sclk(sclk)
  );

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One frame: start, wait, late read of n clocks, release
  task automatic do_frame(input logic [12:0] a, input int n, input int late);
    int cyc;
    logic [15:0] bits;
    logic [15:0] full;
    ain = a;
    full = {1'b1, a[12:1], 3'b000};
    host.start();
    host.tick(6);
    check(16'({doutOe, dout, holdSample}), 16'h0005);
    host.wait_eoc(cyc);
    check(16'(cyc < 182), 16'h0001);
    check(16'(holdSample), 16'h0000);
    check(16'(dacCode), 16'(a[12:1]));
    host.tick(late);
    check(16'(doutWire), 16'h0001);
    host.clock_in(n, bits);
    check(bits, full >> (16 - n));
    host.stop();
    host.tick(4);
    check(16'(doutOe), 16'h0000);
    host.tick(40);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check(16'({doutOe, holdSample, powerUp}), 16'h0000);
    host.tick(12);
    check(16'(doutOe), 16'h0000);
  endtask

  task automatic t_reads();
    do_frame(13'h1555, 16, 0);
    do_frame(13'h0aab, 13, 0);
    do_frame(13'h1fff, 16, 300);
    do_frame(13'h0001, 13, 0);
  endtask

  task automatic t_abort();
    ain = 13'h0f0f;
    host.start();
    host.tick(60);
    host.stop();
    host.tick(4);
    check(16'({doutOe, holdSample}), 16'h0000);
    host.tick(40);
    do_frame(13'h0333, 16, 0);
  endtask

  task automatic t_power();
    pdLow = 1'b1;
    host.tick(5);
    check(16'({powerUp, refEnable}), 16'h0000);
    host.start();
    host.tick(10);
    check(16'(doutOe), 16'h0000);
    host.stop();
    pdLow = 1'b0;
    pdFloat = 1'b1;
    host.tick(5);
    check(16'({powerUp, refEnable}), 16'h0002);
    host.tick(100);
    do_frame(13'h0777, 16, 0);
    pdFloat = 1'b0;
    host.tick(5);
    check(16'({powerUp, refEnable}), 16'h0003);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    rst = 1'b1;
    pdFloat = 1'b0;
    pdLow = 1'b0;
    ain = 13'h0001;
    lastDout = 1'b0;
    repeat (12) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    t_reset();
    t_reads();
    t_abort();
    t_power();
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    finish_test();
  end
endmodule // test_serial_adc_port
